//--- hdl/pll_base_clock_selector.sv
// digital control of the clock generator: base clock selection and pll control registers
// assumes source clocks and status inputs are slow against clk_i and synchronous
// assumes a classic wishbone master with 32-bit data, registers in byte lane 0

// What this block does
// (RULE1) switch waits three old, three new edges
// (RULE2) base clock frozen during source switch
// (RULE3) chosen source divided by two
// (RULE4) bus clock is half base clock
// (RULE5) select bit picks vco, else crystal
// (RULE6) select set ignored while pll off
// (RULE7) power clear ignored while vco selected
// (RULE8) power and select never change together
// (RULE9) zero range disables pll, forces crystal
// (RULE10) multiplier zero behaves as one
// (RULE11) program register: multiplier high, range low
// (RULE12) oscillator enable gates crystal and pll
// (RULE13) lock detector drives interrupt output
// (RULE14) interrupt enable bit is read write
// (RULE15) enable ignores writes, reads zero manual
// (RULE16) flag set on every lock toggle in auto mode
// (RULE17) irq while flag and enable set
// (RULE18) flag reads zero in manual mode
// (RULE19) control register read clears flag
// (RULE20) reset clears enable and flag
// (RULE21) power bit resets set
// (RULE22) reset and stop clear select
// (RULE23) lock status read only in auto
// (RULE24) auto bit selects bandwidth mode
// (RULE25) source edges through synchronisers
// (RULE26) program writes ignored while pll on
module pll_base_clock_selector (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // source clocks
  input  wire logic        crystal_clock_i,
  input  wire logic        vco_clock_i,
  // system integration and lock detector
  input  wire logic        osc_enable_in_i,
  input  wire logic        stop_i,
  input  wire logic        lock_i,
  // clock outputs
  output logic             base_clock_out_o,
  output logic             bus_clock_o,
  // pll control outputs
  output logic             pll_irq_out_o,
  output logic             pll_enable_o,
  output logic             osc_run_o,
  output logic      [3:0]  multiplier_n_o,
  output logic      [3:0]  range_factor_o
);

  typedef struct packed {
    logic                  irq_en;
    logic                  flag;
    logic                  power;
    logic                  select;
    logic                  auto_bw;
    logic                  lock_seen;
    logic [3:0]            mul;
    logic [3:0]            rng;
    pll_clk_pkg::switch_e  sw;
    logic [1:0]            edges;
    logic                  cur_vco;
    logic                  base;
    logic                  bus;
    logic                  irq;
    logic                  pll_en;
    logic                  osc_run;
    logic [3:0]            mul_n;
    logic                  ack;
    logic [31:0]           rdat;
  } state_s;

  state_s s;
  state_s next_s;

  logic xtal_rise;
  logic vco_rise;
  logic access;
  logic wr_lane;
  logic rd_ctl;
  logic toggle;
  logic old_rise;
  logic new_rise;
  logic [7:0] wbyte;

  // ==========================================================================
  // helpers
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  function automatic logic [3:0] feedback_n(input logic [3:0] mul);
    feedback_n = (mul == 4'h0) ? 4'h1 : mul;
  endfunction

  // ==========================================================================
  // source edge sampling
  source_edge_detect u_xtal_edge (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .src_i    (crystal_clock_i),
    .enable_i (osc_enable_in_i),
    .rise_o   (xtal_rise)
  ); // [RULE25] [RULE12]

  source_edge_detect u_vco_edge (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .src_i    (vco_clock_i),
    .enable_i (s.pll_en),
    .rise_o   (vco_rise)
  ); // [RULE25] [RULE12]

  // ==========================================================================
  // bus decode
  assign access   = cyc_i & stb_i & ~s.ack;
  assign wr_lane  = access & we_i & sel_i[0];
  assign rd_ctl   = access & ~we_i & hit(adr_i, pll_clk_pkg::OFF_CONTROL);
  assign wbyte    = dat_i[7:0];
  assign toggle   = s.auto_bw & (lock_i != s.lock_seen);
  assign old_rise = s.cur_vco ? vco_rise : xtal_rise;
  assign new_rise = s.cur_vco ? xtal_rise : vco_rise;

  // ==========================================================================
  // next state
  always_comb begin
    next_s           = s;
    next_s.ack       = access;
    next_s.rdat      = 32'h0;
    next_s.lock_seen = lock_i;

    // read data, low byte only
    if (access && !we_i) begin
      if (hit(adr_i, pll_clk_pkg::OFF_CONTROL)) begin
        next_s.rdat[pll_clk_pkg::CTL_IRQ_EN_BIT] = s.irq_en & s.auto_bw; // [RULE15]
        next_s.rdat[pll_clk_pkg::CTL_FLAG_BIT]   = s.flag & s.auto_bw;   // [RULE18]
        next_s.rdat[pll_clk_pkg::CTL_POWER_BIT]  = s.power;
        next_s.rdat[pll_clk_pkg::CTL_SELECT_BIT] = s.select;
        next_s.rdat[3:0]                         = pll_clk_pkg::CTL_LOW_READ;
      end else if (hit(adr_i, pll_clk_pkg::OFF_BANDWIDTH)) begin
        next_s.rdat[pll_clk_pkg::BW_AUTO_BIT] = s.auto_bw;
        next_s.rdat[pll_clk_pkg::BW_LOCK_BIT] = lock_i & s.auto_bw; // [RULE23]
      end else if (hit(adr_i, pll_clk_pkg::OFF_PROGRAM)) begin
        next_s.rdat[7:0] = {s.mul, s.rng}; // [RULE11]
      end
    end

    // control register write
    if (wr_lane && hit(adr_i, pll_clk_pkg::OFF_CONTROL)) begin
      if (s.auto_bw) begin
        next_s.irq_en = wbyte[pll_clk_pkg::CTL_IRQ_EN_BIT]; // [RULE14] [RULE15]
      end
      // stop or zero range in the same cycle would clear select under the write
      if (!stop_i && s.rng != 4'h0) begin
        if (wbyte[pll_clk_pkg::CTL_POWER_BIT] != s.power &&
            wbyte[pll_clk_pkg::CTL_SELECT_BIT] != s.select) begin
          next_s.power  = s.power; // [RULE8]
        end else if (wbyte[pll_clk_pkg::CTL_POWER_BIT] != s.power) begin
          if (!(s.select && !wbyte[pll_clk_pkg::CTL_POWER_BIT])) begin
            next_s.power = wbyte[pll_clk_pkg::CTL_POWER_BIT]; // [RULE7]
          end
        end else if (wbyte[pll_clk_pkg::CTL_SELECT_BIT] != s.select) begin
          if (s.power || !wbyte[pll_clk_pkg::CTL_SELECT_BIT]) begin
            next_s.select = wbyte[pll_clk_pkg::CTL_SELECT_BIT]; // [RULE6] [RULE5]
          end
        end
      end
    end

    // bandwidth register write
    if (wr_lane && hit(adr_i, pll_clk_pkg::OFF_BANDWIDTH)) begin
      next_s.auto_bw = wbyte[pll_clk_pkg::BW_AUTO_BIT]; // [RULE24]
    end

    // program register write, locked out while pll is on
    if (wr_lane && hit(adr_i, pll_clk_pkg::OFF_PROGRAM) && !s.power) begin
      next_s.mul = wbyte[pll_clk_pkg::PRG_MUL_LSB +: 4]; // [RULE26] [RULE11]
      next_s.rng = wbyte[pll_clk_pkg::PRG_RANGE_LSB +: 4];
    end

    // lock change flag, set wins over the read clear
    if (toggle) begin
      next_s.flag = 1'b1; // [RULE16]
    end else if (rd_ctl) begin
      next_s.flag = 1'b0; // [RULE19]
    end

    // forced deselect
    if (stop_i || s.rng == 4'h0) begin
      next_s.select = 1'b0; // [RULE22] [RULE9]
    end

    // derived outputs
    next_s.irq     = s.flag & s.irq_en & s.auto_bw; // [RULE17] [RULE13]
    next_s.pll_en  = s.power & osc_enable_in_i & (s.rng != 4'h0); // [RULE9] [RULE12]
    next_s.osc_run = osc_enable_in_i; // [RULE12]
    next_s.mul_n   = feedback_n(s.mul); // [RULE10]

    // source switch sequencer, base clock frozen outside run
    case (s.sw)
      pll_clk_pkg::SW_RUN: begin
        if (s.select != s.cur_vco) begin
          next_s.sw    = pll_clk_pkg::SW_DRAIN_OLD; // [RULE1]
          next_s.edges = 2'h0;
        end else if (old_rise) begin
          next_s.base = ~s.base; // [RULE3] [RULE5]
          if (!s.base) begin
            next_s.bus = ~s.bus; // [RULE4]
          end
        end
      end
      pll_clk_pkg::SW_DRAIN_OLD: begin
        if (old_rise) begin
          next_s.edges = s.edges + 2'h1;
          if (s.edges == pll_clk_pkg::SWITCH_EDGES - 2'h1) begin
            next_s.sw    = pll_clk_pkg::SW_FILL_NEW; // [RULE1] [RULE2]
            next_s.edges = 2'h0;
          end
        end
      end
      pll_clk_pkg::SW_FILL_NEW: begin
        if (new_rise) begin
          next_s.edges = s.edges + 2'h1;
          if (s.edges == pll_clk_pkg::SWITCH_EDGES - 2'h1) begin
            next_s.sw      = pll_clk_pkg::SW_RUN; // [RULE1] [RULE2]
            next_s.edges   = 2'h0;
            next_s.cur_vco = ~s.cur_vco;
          end
        end
      end
      default: begin
        next_s.sw = pll_clk_pkg::SW_RUN;
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0; // [RULE20] [RULE22]
      s.power  <= pll_clk_pkg::POWER_RESET; // [RULE21]
      s.mul    <= pll_clk_pkg::PROGRAM_RESET[7:4];
      s.rng    <= pll_clk_pkg::PROGRAM_RESET[3:0];
      s.sw     <= pll_clk_pkg::SW_RUN;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign dat_o            = s.rdat;
  assign ack_o            = s.ack;
  assign base_clock_out_o = s.base;
  assign bus_clock_o      = s.bus;
  assign pll_irq_out_o    = s.irq;
  assign pll_enable_o     = s.pll_en;
  assign osc_run_o        = s.osc_run;
  assign multiplier_n_o   = s.mul_n;
  assign range_factor_o   = s.rng;

  // ==========================================================================
  // checks
  sequence s_switch_request;
    s.sw == pll_clk_pkg::SW_RUN && s.select != s.cur_vco;
  endsequence

  sequence s_drain_entered;
    s.sw == pll_clk_pkg::SW_DRAIN_OLD && s.edges == 2'h0;
  endsequence

  property p_switch_start;
    @(posedge clk_i) disable iff (rst_i)
      s_switch_request |=> s_drain_entered;
  endproperty
  a_switch_start: assert property (p_switch_start) else $error("switch did not start"); // [RULE1]

  property p_frozen;
    @(posedge clk_i) disable iff (rst_i)
      (s.sw != pll_clk_pkg::SW_RUN) |=> $stable(s.base) && $stable(s.bus);
  endproperty
  a_frozen: assert property (p_frozen) else $error("base clock moved during switch"); // [RULE2]

  property p_bus_half;
    @(posedge clk_i) disable iff (rst_i)
      $changed(s.bus) |-> $rose(s.base);
  endproperty
  a_bus_half: assert property (p_bus_half) else $error("bus clock not half base"); // [RULE4]

  property p_select_guard;
    @(posedge clk_i) disable iff (rst_i)
      $rose(s.select) |-> $past(s.power) && s.power;
  endproperty
  a_select_guard: assert property (p_select_guard) else $error("vco selected with pll off"); // [RULE6]

  property p_power_guard;
    @(posedge clk_i) disable iff (rst_i)
      $fell(s.power) |-> !$past(s.select);
  endproperty
  a_power_guard: assert property (p_power_guard) else $error("pll off while selected"); // [RULE7]

  property p_no_joint;
    @(posedge clk_i) disable iff (rst_i)
      $changed(s.power) |-> $stable(s.select);
  endproperty
  a_no_joint: assert property (p_no_joint) else $error("power and select changed together"); // [RULE8]

  property p_range_zero;
    @(posedge clk_i) disable iff (rst_i)
      (s.rng == 4'h0) |=> !s.select ##1 !s.pll_en;
  endproperty
  a_range_zero: assert property (p_range_zero) else $error("zero range left pll usable"); // [RULE9]

  property p_mul_zero;
    @(posedge clk_i) disable iff (rst_i)
      (s.mul == 4'h0) [*2] |-> s.mul_n == 4'h1;
  endproperty
  a_mul_zero: assert property (p_mul_zero) else $error("multiplier zero not one"); // [RULE10]

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
      toggle |=> s.flag ##1 (s.irq == ($past(s.irq_en) && $past(s.auto_bw)));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("lock toggle lost"); // [RULE16]

  property p_read_clear;
    @(posedge clk_i) disable iff (rst_i)
      rd_ctl && !toggle |=> !s.flag;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("control read kept flag"); // [RULE19]

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
      s.irq |-> $past(s.flag) && $past(s.irq_en) && $past(s.auto_bw);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag and enable"); // [RULE17]

  property p_reset;
    @(posedge clk_i) rst_i |=> !s.irq_en && !s.flag && s.power && !s.select;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state"); // [RULE20]

  property p_stop;
    @(posedge clk_i) disable iff (rst_i)
      stop_i |=> !s.select;
  endproperty
  a_stop: assert property (p_stop) else $error("stop kept vco selected"); // [RULE22]

endmodule

//--- hdl/source_edge_detect.sv
// rising edge detector for a free running source clock sampled by clk_i
// assumes the source runs well below half the clk_i rate
module source_edge_detect (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // source
  input  wire logic src_i,
  input  wire logic enable_i,
  // edge pulse
  output logic      rise_o
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } sample_s;

  sample_s s;
  sample_s next_s;

  // ==========================================================================
  // two stage synchroniser, third stage only for edge detection
  always_comb begin
    next_s       = s;
    next_s.sync1 = src_i;
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // gated source yields no edges at all
  assign rise_o = s.sync2 & ~s.prev & enable_i;

endmodule

//--- pkg/pll_clk_pkg.sv
// constants, field positions and types shared by the clock selector design
// assumes byte addressing on a 32-bit classic wishbone bus, 8-bit registers in the low lane
package pll_clk_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_BANDWIDTH = 8'h04;
  localparam logic [7:0] OFF_PROGRAM   = 8'h08;

  // ==========================================================================
  // control register fields
  localparam int CTL_IRQ_EN_BIT = 7;
  localparam int CTL_FLAG_BIT   = 6;
  localparam int CTL_POWER_BIT  = 5;
  localparam int CTL_SELECT_BIT = 4;
  localparam logic [3:0] CTL_LOW_READ = 4'hf;

  // ==========================================================================
  // bandwidth register fields
  localparam int BW_AUTO_BIT = 7;
  localparam int BW_LOCK_BIT = 6;

  // ==========================================================================
  // program register fields
  localparam int PRG_MUL_LSB   = 4;
  localparam int PRG_RANGE_LSB = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] PROGRAM_RESET = 8'h66;
  localparam logic       POWER_RESET   = 1'b1;

  // ==========================================================================
  // source switch timing, in edges of each source
  localparam logic [1:0] SWITCH_EDGES = 2'h3;

  // ==========================================================================
  // source switch sequencer states
  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN_OLD,
    SW_FILL_NEW
  } switch_e;

endpackage

//--- tb/source_model.sv
// partner model: crystal and vco source clocks built from the system clock
// assumes clk_i is the bench clock; the vco only runs while the pll is enabled
module source_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pll state
  input  wire logic vco_run_i,
  // source clocks
  output logic      crystal_clock_o,
  output logic      vco_clock_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // dividers: crystal half period 8 clk, vco half period 5 clk
  // both stay well below clk/4 so the design's synchronisers see every edge
  logic [3:0] xtal_cnt;
  logic [3:0] vco_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_cnt        <= 4'h0;
      vco_cnt         <= 4'h0;
      crystal_clock_o <= 1'b0;
      vco_clock_o     <= 1'b0;
    end else begin
      xtal_cnt <= (xtal_cnt == 4'h7) ? 4'h0 : xtal_cnt + 4'h1;
      if (xtal_cnt == 4'h7) begin
        crystal_clock_o <= ~crystal_clock_o;
      end
      // a disabled vco has no edges at all, parked low
      if (!vco_run_i) begin
        vco_cnt     <= 4'h0;
        vco_clock_o <= 1'b0;
      end else begin
        vco_cnt <= (vco_cnt == 4'h4) ? 4'h0 : vco_cnt + 4'h1;
        if (vco_cnt == 4'h4) begin
          vco_clock_o <= ~vco_clock_o;
        end
      end
    end
  end
endmodule

//--- tb/tb.sv
// testbench for the base clock selector: register tasks over classic wishbone
// assumes the design answers each access with a one-cycle ack
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // signals
  localparam logic [7:0] A_CTL = pll_clk_pkg::OFF_CONTROL;
  localparam logic [7:0] A_BW  = pll_clk_pkg::OFF_BANDWIDTH;
  localparam logic [7:0] A_PRG = pll_clk_pkg::OFF_PROGRAM;
  logic        clk_i = 1'b0;
  logic        rst_i, cyc_i, stb_i, we_i, osc_enable_in_i, stop_i, lock_i;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0]  sel_i, multiplier_n_o, range_factor_o;
  logic        ack_o, crystal_clock_i, vco_clock_i, base_clock_out_o, bus_clock_o;
  logic        pll_irq_out_o, pll_enable_o, osc_run_o;
  int          failures = 0;
  int          compares = 0;

  always #25 clk_i = ~clk_i;

  pll_base_clock_selector u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .crystal_clock_i(crystal_clock_i), .vco_clock_i(vco_clock_i),
    .osc_enable_in_i(osc_enable_in_i), .stop_i(stop_i), .lock_i(lock_i),
    .base_clock_out_o(base_clock_out_o), .bus_clock_o(bus_clock_o),
    .pll_irq_out_o(pll_irq_out_o), .pll_enable_o(pll_enable_o), .osc_run_o(osc_run_o),
    .multiplier_n_o(multiplier_n_o), .range_factor_o(range_factor_o));

  source_model u_src (.clk_i(clk_i), .rst_i(rst_i), .vco_run_i(pll_enable_o),
    .crystal_clock_o(crystal_clock_i), .vco_clock_o(vco_clock_i));

  // ==========================================================================
  // report and checks
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic timeout();
    failures++;
    summarize();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask

  // ==========================================================================
  // wishbone single cycle; no fixed latency assumed
  task automatic bus_op(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    if (n >= 20) timeout();
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus_op(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus_op(1'b0, a, 8'h00, r);
    chk(r, exp);
  endtask

  // rising edge to rising edge, in clk cycles
  task automatic period(input logic pick_bus, input int exp);
    int   n;
    logic s, p;
    s = pick_bus ? bus_clock_o : base_clock_out_o;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        p = s;
        @(posedge clk_i);
        s = pick_bus ? bus_clock_o : base_clock_out_o;
        n++;
      end while (!(p === 1'b0 && s === 1'b1) && n < 300);
    end
    if (n >= 300) timeout();
    chk(32'(n), 32'(exp));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    logic b;
    int   moves;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h00000000;
    sel_i = 4'h0;
    osc_enable_in_i = 1'b1;
    stop_i = 1'b0;
    lock_i = 1'b0;
    tick(6);
    rst_i <= 1'b0;
    rd(A_CTL, 32'h2f);
    rd(A_BW, 32'h00);
    rd(A_PRG, 32'h66);
    rd(8'h0c, 32'h00);
    wr(A_PRG, 8'h34);
    rd(A_PRG, 32'h66);
    period(1'b0, 32);
    period(1'b1, 64);
    // switch to vco: output must stay frozen while old edges drain
    wr(A_CTL, 8'h30);
    b = base_clock_out_o;
    moves = 0;
    repeat (30) begin
      @(posedge clk_i);
      if (base_clock_out_o !== b) moves++;
    end
    chk(32'(moves), 32'h0);
    tick(200);
    period(1'b0, 20);
    period(1'b1, 40);
    rd(A_CTL, 32'h3f);
    wr(A_CTL, 8'h10);
    rd(A_CTL, 32'h3f);
    stop_i <= 1'b1;
    tick(3);
    stop_i <= 1'b0;
    rd(A_CTL, 32'h2f);
    tick(200);
    period(1'b0, 32);
    wr(A_CTL, 8'h00);
    rd(A_CTL, 32'h0f);
    wr(A_CTL, 8'h30);
    rd(A_CTL, 32'h0f);
    wr(A_CTL, 8'h10);
    rd(A_CTL, 32'h0f);
    wr(A_PRG, 8'h40);
    rd(A_PRG, 32'h40);
    tick(2);
    chk({24'h0, multiplier_n_o, range_factor_o}, 32'h40);
    wr(A_PRG, 8'h05);
    tick(2);
    chk({24'h0, multiplier_n_o, range_factor_o}, 32'h15);
    wr(A_PRG, 8'h40);
    wr(A_CTL, 8'h20);
    rd(A_CTL, 32'h0f);
    chk({31'h0, pll_enable_o}, 32'h0);
    wr(A_PRG, 8'h66);
    wr(A_CTL, 8'h20);
    tick(2);
    chk({31'h0, pll_enable_o}, 32'h1);
    osc_enable_in_i <= 1'b0;
    tick(3);
    chk({30'h0, osc_run_o, pll_enable_o}, 32'h0);
    osc_enable_in_i <= 1'b1;
    // lock changes in manual mode leave no trace
    lock_i <= 1'b1;
    tick(4);
    rd(A_CTL, 32'h2f);
    wr(A_CTL, 8'ha0);
    rd(A_CTL, 32'h2f);
    wr(A_BW, 8'h80);
    rd(A_BW, 32'hc0);
    wr(A_CTL, 8'ha0);
    rd(A_CTL, 32'haf);
    chk({31'h0, pll_irq_out_o}, 32'h0);
    lock_i <= 1'b0;
    tick(4);
    chk({31'h0, pll_irq_out_o}, 32'h1);
    rd(A_BW, 32'h80);
    rd(A_CTL, 32'hef);
    rd(A_CTL, 32'haf);
    tick(3);
    chk({31'h0, pll_irq_out_o}, 32'h0);
    wr(A_CTL, 8'h20);
    lock_i <= 1'b1;
    tick(4);
    chk({31'h0, pll_irq_out_o}, 32'h0);
    rd(A_CTL, 32'h6f);
    // mid-run reset while vco selected and interrupt enabled
    wr(A_CTL, 8'ha0);
    wr(A_CTL, 8'hb0);
    rd(A_CTL, 32'hbf);
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    wr(A_BW, 8'h80);
    rd(A_CTL, 32'h2f);
    summarize();
  end

  // ==========================================================================
  // watchdog against a hung wait
  initial begin
    repeat (100000) @(posedge clk_i);
    timeout();
  end
endmodule
